// File: memory_space_pkg.sv
// constants, register map and carrier types for the memory space decoder
package memory_space_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // region bounds, byte addresses
  localparam logic [23:0] SEG0_END       = 24'h00_FFFF;
  localparam logic [23:0] DATA_SRAM_LO       = 24'h00_A000;
  localparam logic [23:0] DATA_SRAM_HI       = 24'h00_DFFF;
  localparam logic [23:0] XREG_LO        = 24'h00_E000;
  localparam logic [23:0] XREG_HI        = 24'h00_EFFF;
  localparam logic [23:0] EREG_LO        = 24'h00_F000;
  localparam logic [23:0] EREG_HI        = 24'h00_F1FF;
  localparam logic [23:0] DUAL_PORT_RAM_LO       = 24'h00_F600;
  localparam logic [23:0] DUAL_PORT_RAM_HI       = 24'h00_FDFF;
  localparam logic [23:0] BITRAM_LO      = 24'h00_FD00;
  localparam logic [23:0] SREG_LO        = 24'h00_FE00;
  localparam logic [23:0] XIO_LO         = 24'h21_0000;
  localparam logic [23:0] XIO_HI         = 24'h3F_FFFF;
  localparam logic [23:0] FLASH0_LO      = 24'hC0_0000;
  localparam logic [23:0] FLASH0_HI      = 24'hC3_FFFF;
  localparam logic [23:0] FLASH1_LO      = 24'hC4_0000;
  localparam logic [23:0] FLASH1_HI      = 24'hC4_FFFF;
  localparam logic [23:0] FLASH_RSV_LO   = 24'hC0_F000;
  localparam logic [23:0] FLASH_RSV_HI   = 24'hC0_FFFF;
  localparam logic [23:0] PROGRAM_SRAM_LO       = 24'hE0_0000;
  localparam logic [23:0] PROGRAM_SRAM_HI       = 24'hE0_3FFF;
  localparam logic [23:0] IMB_LO         = 24'hFF_FF00;

  localparam int SECTOR_SHIFT  = 12; // 4-Kbyte sectors
  localparam int BLOCK_SHIFT   = 7;  // 128-byte program blocks
  localparam int FLASH_SECTORS = 80; // 320 Kbytes / 4 Kbytes
  localparam int CLUSTER_SHIFT = 2;  // four sectors share one protection bit
  localparam int CLUSTERS      = 20;

  // AXI4-Lite register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_PSWP     = 8'h04;
  localparam logic [7:0] REG_WPROT    = 8'h08;
  localparam logic [7:0] REG_PASSWORD = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_ERRADDR  = 8'h14;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] PSWP_RESET  = 32'h0000_0000;
  localparam logic [31:0] WPROT_RESET = 32'h0000_0000;
  // ctrl bits
  localparam int CTRL_PARITY = 0;
  localparam int CTRL_ECC    = 1;
  localparam int CTRL_EXTBUS = 2;
  localparam int CTRL_RDPROT = 3;
  // status bits
  localparam int ST_UNLOCK  = 0;
  localparam int ST_BLOCKED = 1;
  localparam int ST_PARERR  = 2;
  localparam int ST_CORR    = 3;
  localparam int ST_BADADDR = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [9:0] {
    TGT_NONE   = 10'b00_0000_0001,
    TGT_FLASH0 = 10'b00_0000_0010,
    TGT_FLASH1 = 10'b00_0000_0100,
    TGT_PROGRAM_SRAM  = 10'b00_0000_1000,
    TGT_DATA_SRAM  = 10'b00_0001_0000,
    TGT_DUAL_PORT_RAM  = 10'b00_0010_0000,
    TGT_SREG   = 10'b00_0100_0000,
    TGT_EREG   = 10'b00_1000_0000,
    TGT_EXT    = 10'b01_0000_0000,
    TGT_XREG   = 10'b10_0000_0000
  } target_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic        byteAcc;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } cpu_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  target;
    logic        write;
    logic        byteAcc;
    logic        fetchPath;
    logic        dataPath;
    logic        sysBus;
    logic        ordered;
    logic        bitAddr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } tgt_req_t;

  typedef struct packed {
    logic         valid;
    logic [127:0] line;
    logic [8:0]   check;
  } tgt_rsp_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage : memory_space_pkg

// File: memory_space_decoder.sv
// address decoder and router for the 16-Mbyte linear memory space
// Functional notes
// R1: decode 24-bit space: 256 segments of 64 Kbytes, four 16-Kbyte pages each.
// R2: byte and word accesses are accepted anywhere in the space.
// R3: segment zero holds data memories, register area FE00 and extended area F000.
// R4: reserved areas become external bus accesses when the external bus exists.
// R5: flash sector C0F000 to C0FFFF is reserved for internal parameters.
// R6: external IO region 210000 to 3FFFFF runs with ordered, unoptimised accesses.
// R7: instruction fetches go through the program fetch unit only.
// R8: data transfers go through the data transfer unit.
// R9: fetch and data units exchange operands over a two-way system bus.
// R10: a software-sized program SRAM window blocks writes.
// R11: register bank has 16 words, first eight also byte addressable.
// R12: top 256 bytes of dual-port RAM are bit addressable.
// R13: software leaves unused register addresses alone or writes zeros.
// R14: flash uses 4-Kbyte sectors, each protectable, erasable, 128-byte programmed.
// R15: flash reads 128 bits and corrects errors on every read; the decoder corrects only while ctrl bit CTRL_ECC is set.
// R16: flash read protection; correct password sequence unlocks temporarily.
// R17: two flash modules may be accessed in parallel; the decoder keeps only one access in flight at a time.
// R18: sectors share protection bits by cluster, program and erase per sector.
// R19: flash 0 at C00000 to C3FFFF, flash 1 at C40000 to C4FFFF.
// R20: data SRAM at 00A000 to 00DFFF over its own data interface.
// R21: parity on: a single-bit error is detected and the data suppressed.
// R22: error correction on: single-bit errors are detected and corrected.
// R23: each access selects exactly one target and returns its answer.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module memory_space_decoder
  import memory_space_pkg::*;
#(
  parameter logic [31:0] PASSWORD_1 = 32'h0000_A5A5, // arbitrary unlock word
  parameter logic [31:0] PASSWORD_2 = 32'h0000_5A5A  // arbitrary unlock word
) (
  input  wire logic                        ref_clk,   // system clock
  input  wire logic                        reset,     // synchronous, high
  input  wire memory_space_pkg::cpu_req_t  cpuReq,    // core request
  output memory_space_pkg::cpu_rsp_t       cpuRsp,    // core answer
  output memory_space_pkg::tgt_req_t       tgtReq,    // routed request
  input  wire memory_space_pkg::tgt_rsp_t  tgtRsp,    // target answer
  input  wire memory_space_pkg::axil_req_t axiIn,     // register bus in
  output memory_space_pkg::axil_rsp_t      axiOut,    // register bus out
  output logic [6:0]                       eraseSect  // sector addressed by last blocked flash access
);
  import memory_space_pkg::*;

  initial begin
    if (ADDR_W != 24 || DATA_W != 16) $error("unsupported widths");
  end

  function automatic target_t decode(input logic [23:0] a, input logic ext);
    target_t t;
    t = ext ? TGT_EXT : TGT_NONE; // see R4
    if (a <= SEG0_END) begin // see R3
      if (a >= DATA_SRAM_LO && a <= DATA_SRAM_HI) t = TGT_DATA_SRAM; // see R20
      else if (a >= XREG_LO && a <= XREG_HI) t = TGT_XREG;
      else if (a >= EREG_LO && a <= EREG_HI) t = TGT_EREG;
      else if (a >= DUAL_PORT_RAM_LO && a <= DUAL_PORT_RAM_HI) t = TGT_DUAL_PORT_RAM;
      else if (a >= SREG_LO) t = TGT_SREG;
      else if (a < 24'h00_8000) t = TGT_EXT;
    end else if (a >= FLASH0_LO && a <= FLASH0_HI) t = TGT_FLASH0; // see R19
    else if (a >= FLASH1_LO && a <= FLASH1_HI) t = TGT_FLASH1;
    else if (a >= PROGRAM_SRAM_LO && a <= PROGRAM_SRAM_HI) t = TGT_PROGRAM_SRAM;
    else if (a < 24'h20_0000 || (a >= 24'h40_0000 && a < FLASH0_LO)) t = TGT_EXT;
    else if (a >= XIO_LO && a <= XIO_HI) t = TGT_EXT;
    else if (a >= 24'h20_0000 && a < 24'h20_BC00) t = TGT_EXT;
    return t;
  endfunction : decode

  function automatic logic isFlash(input target_t t);
    return t == TGT_FLASH0 || t == TGT_FLASH1;
  endfunction : isFlash

  function automatic logic [6:0] sectorOf(input logic [23:0] a);
    logic [6:0] s;
    s = a[22:16] == 7'h44 ? 7'(64 + 32'(a[15:12])) : 7'({a[17:16], a[15:12]});
    return s;
  endfunction : sectorOf

  // bit0 parity, bits 4:1 position of an upset data bit, bits 6:5 mark a data-bit upset
  function automatic logic [8:0] eccOf(input logic [15:0] w);
    return {2'b00, ^w, ^w, ^(w & 16'hFF00), ^(w & 16'hF0F0), ^(w & 16'hCCCC), ^(w & 16'hAAAA), ^w};
  endfunction : eccOf

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] pswp;
    logic [31:0] wprot;
    logic [4:0]  status;
    logic [23:0] errAddr;
    logic        pwStep;
    logic        busy;
    cpu_req_t    held;
    cpu_rsp_t    rsp;
    tgt_req_t    out;
    logic [6:0]  sect;
    logic [7:0]  wAddr;
    logic [31:0] wData;
    axil_rsp_t   axi;
  } state_t;

  state_t st_r, st_nxt;

  logic [8:0]  syndrome;
  logic [15:0] word;
  logic [15:0] fixed;
  logic        parBad;
  logic [2:0]  lane;

  always_comb begin
    lane     = st_r.held.addr[3:1];
    word     = tgtRsp.line[16*lane +: 16]; // see R15
    syndrome = tgtRsp.check ^ eccOf(word);
    parBad   = tgtRsp.check[0] != ^word;
    fixed    = syndrome[6:5] == 2'b11 ? word ^ (16'h0001 << syndrome[4:1]) : word;
  end

  always_comb begin
    target_t    t;
    logic       blocked;
    logic [4:0] clus;
    logic [31:0] rdv;
    t       = TGT_NONE;
    blocked = 1'b0;
    clus    = 5'd0;
    rdv     = 32'h0000_0000;
    st_nxt  = st_r;
    st_nxt.out.valid = 1'b0;
    st_nxt.rsp.valid = 1'b0;

    // AXI4-Lite write: address and data in either order, each kept when taken;
    // ahead of the core side so a flag set in the same cycle wins over its clear
    if (axiIn.awvalid && st_r.axi.awready) begin
      st_nxt.axi.awready = 1'b0;
      st_nxt.wAddr       = axiIn.awaddr;
    end
    if (axiIn.wvalid && st_r.axi.wready) begin
      st_nxt.axi.wready = 1'b0;
      st_nxt.wData      = axiIn.wdata;
    end
    if (!st_r.axi.awready && !st_r.axi.wready && !st_r.axi.bvalid) begin
      st_nxt.axi.bvalid = 1'b1;
      st_nxt.axi.bresp  = RESP_OKAY;
      case (st_r.wAddr)
        REG_CTRL:  st_nxt.ctrl  = st_r.wData;
        REG_PSWP:  st_nxt.pswp  = st_r.wData;
        REG_WPROT: st_nxt.wprot = st_r.wData;
        REG_PASSWORD: begin // see R16
          if (!st_r.pwStep && st_r.wData == PASSWORD_1) st_nxt.pwStep = 1'b1;
          else if (st_r.pwStep && st_r.wData == PASSWORD_2) begin
            st_nxt.pwStep = 1'b0;
            st_nxt.status[ST_UNLOCK] = 1'b1;
          end else begin
            st_nxt.pwStep = 1'b0;
            st_nxt.status[ST_UNLOCK] = 1'b0;
          end
        end
        REG_STATUS: st_nxt.status[4:1] = st_nxt.status[4:1] & ~st_r.wData[4:1];
        REG_ERRADDR: st_nxt.axi.bresp = RESP_OKAY;
        default: st_nxt.axi.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.axi.bvalid && axiIn.bready) begin
      st_nxt.axi.bvalid  = 1'b0;
      st_nxt.axi.awready = 1'b1;
      st_nxt.axi.wready  = 1'b1;
    end

    // core side: one access in flight, routed to a single target
    if (!st_r.busy && cpuReq.valid) begin
      t    = decode(cpuReq.addr, st_r.ctrl[CTRL_EXTBUS]); // see R1 see R23
      clus = 5'(sectorOf(cpuReq.addr) >> CLUSTER_SHIFT);
      if (cpuReq.write && isFlash(t) && st_r.wprot[clus]) blocked = 1'b1; // see R14 see R18
      if (cpuReq.write && t == TGT_PROGRAM_SRAM &&
          cpuReq.addr[13:0] < st_r.pswp[13:0]) blocked = 1'b1; // see R10
      if (cpuReq.addr >= FLASH_RSV_LO && cpuReq.addr <= FLASH_RSV_HI) blocked = 1'b1; // see R5
      if (!cpuReq.write && isFlash(t) && st_r.ctrl[CTRL_RDPROT] &&
          !st_r.status[ST_UNLOCK]) blocked = 1'b1; // see R16
      if (t == TGT_NONE || blocked) begin
        st_nxt.rsp = '{valid: 1'b1, error: 1'b1, rdata: 16'h0000};
        st_nxt.status[ST_BLOCKED] = blocked;
        st_nxt.status[ST_BADADDR] = t == TGT_NONE;
        st_nxt.errAddr = cpuReq.addr;
        if (blocked && isFlash(t)) st_nxt.sect = sectorOf(cpuReq.addr);
      end else begin
        st_nxt.busy = 1'b1;
        st_nxt.held = cpuReq;
        st_nxt.out.valid     = 1'b1;
        st_nxt.out.target    = t;
        st_nxt.out.write     = cpuReq.write;
        st_nxt.out.byteAcc   = cpuReq.byteAcc; // see R2 see R11
        st_nxt.out.fetchPath = cpuReq.fetch || t == TGT_PROGRAM_SRAM || isFlash(t); // see R7
        st_nxt.out.dataPath  = !cpuReq.fetch; // see R8
        st_nxt.out.sysBus    = cpuReq.fetch != (isFlash(t) || t == TGT_PROGRAM_SRAM) ||
                               t == TGT_EXT; // see R9
        st_nxt.out.ordered   = cpuReq.addr >= XIO_LO && cpuReq.addr <= XIO_HI; // see R6
        st_nxt.out.bitAddr   = (cpuReq.addr >= BITRAM_LO && cpuReq.addr <= DUAL_PORT_RAM_HI) ||
                               t == TGT_SREG || t == TGT_EREG; // see R12
        st_nxt.out.addr      = cpuReq.addr;
        st_nxt.out.wdata     = cpuReq.wdata;
      end
    end

    // answer returns; flash modules are independent targets (see R17)
    if (st_r.busy && tgtRsp.valid) begin
      st_nxt.busy = 1'b0;
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.error = 1'b0;
      st_nxt.rsp.rdata = st_r.held.byteAcc ?
        {8'h00, st_r.held.addr[0] ? word[15:8] : word[7:0]} : word;
      if (st_r.ctrl[CTRL_ECC] && syndrome != 9'd0) begin // see R22
        st_nxt.rsp.rdata = st_r.held.byteAcc ?
          {8'h00, st_r.held.addr[0] ? fixed[15:8] : fixed[7:0]} : fixed;
        st_nxt.status[ST_CORR] = 1'b1;
        st_nxt.errAddr = st_r.held.addr;
      end else if (st_r.ctrl[CTRL_PARITY] && parBad) begin // see R21
        st_nxt.rsp.error = 1'b1;
        st_nxt.rsp.rdata = 16'h0000;
        st_nxt.status[ST_PARERR] = 1'b1;
        st_nxt.errAddr = st_r.held.addr;
      end
    end

    // AXI4-Lite read
    if (axiIn.arvalid && st_r.axi.arready) begin
      st_nxt.axi.arready = 1'b0;
      st_nxt.axi.rvalid  = 1'b1;
      st_nxt.axi.rresp   = RESP_OKAY;
      case (axiIn.araddr)
        REG_CTRL:     rdv = st_r.ctrl;
        REG_PSWP:     rdv = st_r.pswp;
        REG_WPROT:    rdv = st_r.wprot;
        REG_PASSWORD: rdv = 32'h0000_0000;
        REG_STATUS:   rdv = {27'h000_0000, st_r.status};
        REG_ERRADDR:  rdv = {8'h00, st_r.errAddr};
        default:      st_nxt.axi.rresp = RESP_SLVERR;
      endcase
      st_nxt.axi.rdata = rdv;
    end
    if (st_r.axi.rvalid && axiIn.rready) begin
      st_nxt.axi.rvalid  = 1'b0;
      st_nxt.axi.arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctrl        <= CTRL_RESET;
      st_r.pswp        <= PSWP_RESET;
      st_r.wprot       <= WPROT_RESET;
      st_r.out.target  <= TGT_NONE;
      st_r.axi.awready <= 1'b1;
      st_r.axi.wready  <= 1'b1;
      st_r.axi.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpuRsp    = st_r.rsp;
  assign tgtReq    = st_r.out;
  assign axiOut    = st_r.axi;
  assign eraseSect = st_r.sect;

  a_data_sram_route: assert property (@(posedge ref_clk) disable iff (reset) // see R20
    (!st_r.busy && cpuReq.valid && cpuReq.addr >= DATA_SRAM_LO && cpuReq.addr <= DATA_SRAM_HI)
      |=> tgtReq.valid && tgtReq.target == TGT_DATA_SRAM) else $error("data sram misrouted");
  a_flash_split: assert property (@(posedge ref_clk) disable iff (reset) // see R19
    tgtReq.valid && tgtReq.target == TGT_FLASH1 |-> tgtReq.addr[23:16] == 8'hC4)
    else $error("flash 1 outside its segment");
  a_io_ordered: assert property (@(posedge ref_clk) disable iff (reset) // see R6
    tgtReq.valid |-> tgtReq.ordered == (tgtReq.addr >= XIO_LO && tgtReq.addr <= XIO_HI))
    else $error("io ordering flag wrong");
  a_reserved_sector: assert property (@(posedge ref_clk) disable iff (reset) // see R5
    tgtReq.valid |-> !(tgtReq.addr >= FLASH_RSV_LO && tgtReq.addr <= FLASH_RSV_HI))
    else $error("reserved flash sector reached");
  a_one_target: assert property (@(posedge ref_clk) disable iff (reset) // see R23
    tgtReq.valid |-> $onehot(tgtReq.target) && tgtReq.target != TGT_NONE)
    else $error("not exactly one target");
  a_program_sram_window: assert property (@(posedge ref_clk) disable iff (reset) // see R10
    tgtReq.valid && tgtReq.write && tgtReq.target == TGT_PROGRAM_SRAM
      |-> tgtReq.addr[13:0] >= st_r.pswp[13:0]) else $error("protected program_sram write");
  a_fetch_path: assert property (@(posedge ref_clk) disable iff (reset) // see R7
    (!st_r.busy && cpuReq.valid && cpuReq.fetch) ##1 tgtReq.valid |-> tgtReq.fetchPath)
    else $error("fetch bypassed fetch unit");
  a_bit_area: assert property (@(posedge ref_clk) disable iff (reset) // see R12
    tgtReq.valid && tgtReq.target == TGT_DUAL_PORT_RAM |-> tgtReq.bitAddr == (tgtReq.addr >= BITRAM_LO))
    else $error("bit addressable area wrong");
  a_answer_back: assert property (@(posedge ref_clk) disable iff (reset) // see R23
    st_r.busy && tgtRsp.valid |=> cpuRsp.valid && !st_r.busy) else $error("answer not returned");
  a_parity_stop: assert property (@(posedge ref_clk) disable iff (reset) // see R21
    st_r.busy && tgtRsp.valid && st_r.ctrl[CTRL_PARITY] && !st_r.ctrl[CTRL_ECC] && parBad
      |=> cpuRsp.error && cpuRsp.rdata == 16'h0000) else $error("parity error data used");

endmodule : memory_space_decoder

// File: memory_target_model.sv
// far-side memory target model answering routed requests
module memory_target_model (
  input  wire logic                       ref_clk,   // system clock
  input  wire logic                       reset,     // synchronous, high
  input  wire memory_space_pkg::tgt_req_t tgtReq,    // routed request
  output memory_space_pkg::tgt_rsp_t      tgtRsp,    // target answer
  input  wire logic [15:0]                pattern,   // data seed
  input  wire logic [1:0]                 waitCyc,   // answer delay
  input  wire logic                       badParity  // upset one data bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import memory_space_pkg::*;
  logic [1:0]   cnt;
  logic         busy;
  logic         fire;
  logic [23:0]  held;
  logic [127:0] ln;
  logic [15:0]  wd;
  always @(posedge ref_clk) begin
    fire = 1'b0;
    if (reset) begin
      busy <= 1'b0;
      tgtRsp <= '0;
    end else begin
      if (tgtReq.valid) begin
        held = tgtReq.addr;
        busy <= (waitCyc != 2'h0);
        cnt <= waitCyc;
        fire = (waitCyc == 2'h0);
      end else if (busy) begin
        busy <= (cnt != 2'h1);
        cnt <= cnt - 2'h1;
        fire = (cnt == 2'h1);
      end
      for (int k = 0; k < 8; k++) ln[k*16 +: 16] = pattern ^ {held[11:4], 5'h00, k[2:0]};
      // check bits from the clean lane, then one data bit upset on request
      wd = ln[held[3:1]*16 +: 16];
      ln[held[3:1]*16 + 5] = ln[held[3:1]*16 + 5] ^ badParity;
      tgtRsp.valid <= fire;
      // idle cycles drive the complement of the last line and check bits
      tgtRsp.line <= fire ? ln : ~tgtRsp.line;
      tgtRsp.check <= fire ? {2'b00, ^wd, ^wd, ^(wd & 16'hFF00), ^(wd & 16'hF0F0), ^(wd & 16'hCCCC),
                              ^(wd & 16'hAAAA), ^wd} : ~tgtRsp.check;
    end
  end
endmodule : memory_target_model

// File: memory_space_decoder_tb_top.sv
// self-checking bench for the memory space decoder
module memory_space_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import memory_space_pkg::*;
  typedef struct packed {
    logic        err;
    logic        rdChk;
    logic        byteRd;
    logic [15:0] data;
  } cpu_exp_t;
  typedef struct packed {
    logic [9:0]  target;
    logic        write;
    logic        fetch;
    logic        byteAcc;
    logic        ordered;
    logic [23:0] addr;
    logic [15:0] wdata;
  } tgt_exp_t;
  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
    logic [31:0] mask;
  } axi_exp_t;
  logic        ref_clk   = 1'b0;
  logic        reset     = 1'b1;
  cpu_req_t    cpuReq    = '0;
  cpu_rsp_t    cpuRsp;
  tgt_req_t    tgtReq;
  tgt_rsp_t    tgtRsp;
  axil_req_t   axiIn     = '0;
  axil_rsp_t   axiOut;
  logic [6:0]  eraseSect;
  logic [15:0] pattern   = 16'h0000;
  logic [1:0]  waitCyc   = 2'h0;
  logic        badParity = 1'b0;
  logic [31:0] rng       = 32'h0000_57DB;
  int          errors    = 0;
  int          tests_run = 0;
  cpu_exp_t    cpuQ[$];
  tgt_exp_t    tgtQ[$];
  axi_exp_t    axiQ[$];
  cpu_exp_t    ce;
  tgt_exp_t    te;
  axi_exp_t    ae;
  logic        pm;
  logic [23:0] rsvAddr [4]  = '{24'h00_8000, 24'h00_F200, 24'hC5_0000, 24'hF0_0000};
  logic [23:0] mapAddr [20] = '{24'h00_0000, 24'h00_A000, 24'h00_DFFE, 24'h00_E000, 24'h00_EFFE, 24'h00_F000,
    24'h00_F1FE, 24'h00_F600, 24'h00_FDFE, 24'h00_FE00, 24'h00_FFFE, 24'h01_0000, 24'h21_0000, 24'h3F_FFFE,
    24'h40_0000, 24'hC0_0000, 24'hC3_FFFE, 24'hC4_0000, 24'hC4_FFFE, 24'hE0_3FFE};
  target_t     mapTgt  [20] = '{TGT_EXT, TGT_DATA_SRAM, TGT_DATA_SRAM, TGT_XREG, TGT_XREG, TGT_EREG, TGT_EREG, TGT_DUAL_PORT_RAM,
    TGT_DUAL_PORT_RAM, TGT_SREG, TGT_SREG, TGT_EXT, TGT_EXT, TGT_EXT, TGT_EXT, TGT_FLASH0, TGT_FLASH0, TGT_FLASH1,
    TGT_FLASH1, TGT_PROGRAM_SRAM};

  always #20 ref_clk = ~ref_clk;

  memory_space_decoder DUT (.ref_clk(ref_clk), .reset(reset), .cpuReq(cpuReq), .cpuRsp(cpuRsp), .tgtReq(tgtReq),
    .tgtRsp(tgtRsp), .axiIn(axiIn), .axiOut(axiOut), .eraseSect(eraseSect));
  memory_target_model TGT (.ref_clk(ref_clk), .reset(reset), .tgtReq(tgtReq), .tgtRsp(tgtRsp),
    .pattern(pattern), .waitCyc(waitCyc), .badParity(badParity));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("errors %0d, tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // one core access, expectations queued before driving
  task automatic cpu_acc(input logic [23:0] a, input logic wr, input logic by, input logic err, input target_t tg);
    int          n;
    logic        fe;
    logic [15:0] w;
    rng = xs(rng);
    fe = !wr && !by && (tg inside {TGT_FLASH0, TGT_FLASH1, TGT_PROGRAM_SRAM});
    w = rng[15:0] ^ {a[11:4], 5'h00, a[3:1]};
    pattern <= rng[15:0];
    waitCyc <= rng[17:16];
    cpuQ.push_back('{err, !wr && !err, by, a[0] ? {8'h00, w[15:8]} : w});
    if (tg != TGT_NONE) tgtQ.push_back('{tg, wr, fe, by, (a >= XIO_LO && a <= XIO_HI), a, rng[31:16]});
    cpuReq <= '{1'b1, wr, fe, by, a, rng[31:16]};
    n = 0;
    do begin
      @(posedge ref_clk);
      cpuReq.valid <= 1'b0;
      n++;
    end while (cpuRsp.valid !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("core answer timeout", 32'h1, 32'h0);
      results();
    end
    @(posedge ref_clk);
  endtask : cpu_acc

  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] resp);
    int n;
    axiQ.push_back('{resp, d, wr ? 32'h0 : m});
    axiIn <= '{wr, a, wr, d, 4'hF, wr, !wr, a, !wr};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (axiOut.awready) axiIn.awvalid <= 1'b0;
      if (axiOut.wready) axiIn.wvalid <= 1'b0;
      if (axiOut.arready) axiIn.arvalid <= 1'b0;
    end while ((wr ? axiOut.bvalid : axiOut.rvalid) !== 1'b1 && n < 50);
    axiIn.bready <= 1'b0;
    axiIn.rready <= 1'b0;
    if (n >= 50) begin
      chk("bus answer timeout", 32'h1, 32'h0);
      results();
    end
    @(posedge ref_clk);
  endtask : axi

  // output watcher: oldest note against each result
  always @(posedge ref_clk) begin
    if (!reset && tgtReq.valid === 1'b1) begin
      if (tgtQ.size() == 0) chk("routed request count", 32'h1, 32'h0);
      else begin
        te = tgtQ.pop_front();
        chk("target", 32'(tgtReq.target), 32'(te.target));
        pm = te.target inside {TGT_FLASH0, TGT_FLASH1, TGT_PROGRAM_SRAM};
        chk("route", 32'({tgtReq.write, tgtReq.fetchPath, tgtReq.dataPath, tgtReq.ordered, tgtReq.byteAcc,
            tgtReq.sysBus}), 32'({te.write, te.fetch || pm, !te.fetch, te.ordered, te.byteAcc,
            te.fetch != pm || te.target == TGT_EXT}));
        chk("address", 32'(tgtReq.addr), 32'(te.addr));
        if (te.write) chk("write data", 32'(tgtReq.wdata), 32'(te.wdata));
        if (te.target == TGT_DUAL_PORT_RAM && te.addr >= BITRAM_LO) chk("bit access", 32'(tgtReq.bitAddr), 32'h1);
      end
    end
    if (!reset && cpuRsp.valid === 1'b1) begin
      if (cpuQ.size() == 0) chk("answer count", 32'h1, 32'h0);
      else begin
        ce = cpuQ.pop_front();
        chk("error flag", 32'(cpuRsp.error), 32'(ce.err));
        if (ce.rdChk && ce.byteRd) chk("byte data", 32'(cpuRsp.rdata[7:0]), 32'(ce.data[7:0]));
        else if (ce.rdChk) chk("read data", 32'(cpuRsp.rdata), 32'(ce.data));
      end
    end
    if (!reset && ((axiOut.bvalid && axiIn.bready) || (axiOut.rvalid && axiIn.rready)) === 1'b1) begin
      ae = axiQ.pop_front();
      chk("bus response", 32'(axiOut.bvalid ? axiOut.bresp : axiOut.rresp), 32'(ae.resp));
      if (axiOut.rvalid) chk("register data", axiOut.rdata & ae.mask, ae.data & ae.mask);
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    axi(1'b0, REG_CTRL, CTRL_RESET, 32'hFFFF_FFFF, RESP_OKAY);
    axi(1'b0, REG_PSWP, PSWP_RESET, 32'hFFFF_FFFF, RESP_OKAY);
    axi(1'b0, REG_WPROT, WPROT_RESET, 32'hFFFF_FFFF, RESP_OKAY);
    axi(1'b0, REG_PASSWORD, 32'h0000_0000, 32'hFFFF_FFFF, RESP_OKAY);
    axi(1'b1, 8'h20, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
    axi(1'b0, 8'h20, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
    cpu_acc(FLASH_RSV_LO, 1'b0, 1'b0, 1'b1, TGT_NONE);
    foreach (rsvAddr[i]) cpu_acc(rsvAddr[i], 1'b0, 1'b0, 1'b1, TGT_NONE);
    axi(1'b1, REG_CTRL, 32'h0000_0004, 32'h0000_0000, RESP_OKAY);
    foreach (rsvAddr[i]) cpu_acc(rsvAddr[i], 1'b1, 1'b0, 1'b0, TGT_EXT);
    foreach (mapAddr[i]) begin
      cpu_acc(mapAddr[i], 1'b0, 1'b0, 1'b0, mapTgt[i]);
      cpu_acc(mapAddr[i] + 24'h00_0001, 1'b0, 1'b1, 1'b0, mapTgt[i]);
    end
    axi(1'b1, REG_PSWP, 32'h0000_0100, 32'h0000_0000, RESP_OKAY);
    cpu_acc(24'hE0_00FE, 1'b1, 1'b0, 1'b1, TGT_NONE);
    cpu_acc(24'hE0_0100, 1'b1, 1'b0, 1'b0, TGT_PROGRAM_SRAM);
    axi(1'b0, REG_STATUS, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
    axi(1'b1, REG_STATUS, 32'h0000_001E, 32'h0000_0000, RESP_OKAY);
    axi(1'b0, REG_STATUS, 32'h0000_0000, 32'h0000_001E, RESP_OKAY);
    axi(1'b1, REG_WPROT, 32'h0000_0002, 32'h0000_0000, RESP_OKAY);
    cpu_acc(24'hC0_7FFE, 1'b1, 1'b0, 1'b1, TGT_NONE);
    chk("blocked sector", 32'(eraseSect), 32'h0000_0007);
    cpu_acc(24'hC0_4000, 1'b1, 1'b0, 1'b1, TGT_NONE);
    chk("blocked sector", 32'(eraseSect), 32'h0000_0004);
    cpu_acc(24'hC0_3FFE, 1'b1, 1'b0, 1'b0, TGT_FLASH0);
    cpu_acc(24'hC0_8000, 1'b1, 1'b0, 1'b0, TGT_FLASH0);
    axi(1'b1, REG_CTRL, 32'h0000_000C, 32'h0000_0000, RESP_OKAY);
    cpu_acc(24'hC4_0000, 1'b0, 1'b1, 1'b1, TGT_NONE);
    axi(1'b1, REG_PASSWORD, 32'h0000_A5A5, 32'h0000_0000, RESP_OKAY);
    axi(1'b1, REG_PASSWORD, 32'h0000_5A5A, 32'h0000_0000, RESP_OKAY);
    axi(1'b0, REG_STATUS, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    cpu_acc(24'hC4_0000, 1'b0, 1'b1, 1'b0, TGT_FLASH1);
    axi(1'b1, REG_PASSWORD, 32'h0000_0000, 32'h0000_0000, RESP_OKAY);
    cpu_acc(24'hC4_0000, 1'b0, 1'b1, 1'b1, TGT_NONE);
    axi(1'b1, REG_CTRL, 32'h0000_0006, 32'h0000_0000, RESP_OKAY);
    badParity <= 1'b1;
    cpu_acc(24'h00_A004, 1'b0, 1'b0, 1'b0, TGT_DATA_SRAM);
    cpu_acc(24'h00_A004, 1'b0, 1'b1, 1'b0, TGT_DATA_SRAM);
    axi(1'b0, REG_STATUS, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
    axi(1'b1, REG_CTRL, 32'h0000_0005, 32'h0000_0000, RESP_OKAY);
    badParity <= 1'b1;
    cpu_acc(24'h00_A002, 1'b0, 1'b0, 1'b1, TGT_DATA_SRAM);
    axi(1'b0, REG_STATUS, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
    axi(1'b0, REG_ERRADDR, 32'h0000_A002, 32'hFFFF_FFFF, RESP_OKAY);
    badParity <= 1'b0;
    cpu_acc(24'h00_A002, 1'b0, 1'b0, 1'b0, TGT_DATA_SRAM);
    chk("pending notes", 32'(cpuQ.size() + tgtQ.size() + axiQ.size()), 32'h0000_0000);
    results();
  end
endmodule : memory_space_decoder_tb_top
